/* rtl/fci_pkg.sv */
// package of constants and carrier types for the flash command host controller
package fci_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    // time from the falling read strobe until read data is trusted
    localparam int unsigned ACCESS_NS = 100;
    // time after the last command write before the first status poll
    localparam int unsigned SETTLE_NS = 200;
    localparam logic [3:0] ACCESS_CYC = 4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // register map of the controller (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned APB_AW = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ADDR = 12'h004;
    localparam logic [11:0] OFS_WDATA = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00c;
    localparam logic [11:0] OFS_PIN = 12'h010;
    // result register field positions
    localparam int unsigned RES_BUSY = 8;
    localparam int unsigned RES_SEQ_ERR = 9;
    localparam int unsigned RES_ERASE_ERR = 10;
    localparam int unsigned RES_WRITE_ERR = 11;
    localparam int unsigned RES_SUPPLY_LOW = 12;
    localparam int unsigned RES_LOCK = 13;
    localparam int unsigned RES_REFUSED = 14;
    localparam logic RST_POWERDOWN_RESET_N = 1'b1;

    // ------------------------------------------------------------------
    // device side: address width, command bytes, status layout
    // ------------------------------------------------------------------
    localparam int unsigned FLASH_AW = 20;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam int unsigned STS_READY = 7;
    localparam int unsigned STS_SUSPENDED = 6;
    localparam int unsigned STS_ERASE_ERR = 5;
    localparam int unsigned STS_WRITE_ERR = 4;
    localparam int unsigned STS_SUPPLY_LOW = 3;
    localparam logic [7:0] STS_USED_MASK = 8'hf8;

    typedef enum logic [2:0] {
        OP_READ_ARRAY = 3'h0,
        OP_READ_ID = 3'h1,
        OP_READ_STATUS = 3'h2,
        OP_CLEAR_STATUS = 3'h3,
        OP_ERASE = 3'h4,
        OP_WRITE = 3'h5,
        OP_SUSPEND = 3'h6,
        OP_RESUME = 3'h7
    } fci_op_type;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_WR_LOW = 6'h02,
        S_WR_HIGH = 6'h04,
        S_SETTLE = 6'h08,
        S_RD_LOW = 6'h10,
        S_RD_HIGH = 6'h20
    } fci_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fci_apb_req_type;

    typedef struct packed {
        logic ceN;
        logic oeN;
        logic weN;
        logic [FLASH_AW-1:0] addr;
        logic [7:0] dataOut;
        logic dataOe;
    } fci_pins_type;

    localparam fci_pins_type PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0, dataOut: 8'h00, dataOe: 1'b0};

endpackage

/* rtl/fci_host_ctrl.sv */
// host controller that drives a byte-wide flash through its command interface
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - host masks reserved status bits 2..0
// - errors evaluated only after ready seen
// - both error bits after erase mean bad sequence
// - strobes return high between status reads
// - clear status after supply-low before altering
// - erase writes 20H then D0H in block
// - program writes 40H then data
module fci_host_ctrl
    import fci_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire fci_pkg::fci_apb_req_type apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output fci_pkg::fci_pins_type flashPins,
    input wire logic [7:0] flashDataIn,
    input wire logic readyBusyOut,
    output logic powerdownResetN
);
    import fci_pkg::*;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic logic isAlter(input fci_op_type op);
        return (op == OP_ERASE) || (op == OP_WRITE);
    endfunction

    function automatic logic needsPoll(input fci_op_type op);
        return isAlter(op) || (op == OP_SUSPEND);
    endfunction

    function automatic logic readsBack(input fci_op_type op);
        return needsPoll(op) || (op == OP_READ_ARRAY) || (op == OP_READ_ID) || (op == OP_READ_STATUS);
    endfunction

    function automatic logic [7:0] cmdByte(input fci_op_type op, input logic step, input logic [7:0] wd);
        unique case (op)
            OP_READ_ARRAY: return CMD_READ_ARRAY;
            OP_READ_ID: return CMD_READ_ID;
            OP_READ_STATUS: return CMD_READ_STATUS;
            OP_CLEAR_STATUS: return CMD_CLEAR_STATUS;
            OP_ERASE: return step ? CMD_CONFIRM : CMD_ERASE_SETUP;
            OP_WRITE: return step ? wd : CMD_WRITE_SETUP;
            OP_SUSPEND: return CMD_SUSPEND;
            OP_RESUME: return CMD_CONFIRM;
        endcase
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) || (a == OFS_RESULT) || (a == OFS_PIN);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fci_state_type state, next_state;
    fci_op_type op, next_op;
    logic step, next_step;
    logic [3:0] waitCnt, next_waitCnt;
    logic [7:0] rdData, next_rdData;
    logic seqErr, next_seqErr;
    logic eraseErr, next_eraseErr;
    logic writeErr, next_writeErr;
    logic supplyLow, next_supplyLow;
    logic lock, next_lock;
    logic refused, next_refused;
    logic [FLASH_AW-1:0] addrReg, next_addrReg;
    logic [7:0] wdataReg, next_wdataReg;
    logic next_powerdownResetN;
    logic [31:0] next_prdata;
    fci_pins_type next_flashPins;
    logic apbAccess, apbWrite, start;
    logic [31:0] resultWord;

    assign apbAccess = apbReq.psel && apbReq.penable;
    assign apbWrite = apbAccess && apbReq.pwrite;
    assign pready = apbAccess;
    assign pslverr = apbAccess && !mapped(apbReq.paddr);
    // a start request while an operation runs is dropped; software polls busy first
    assign start = apbWrite && (apbReq.paddr == OFS_CTRL) && (state == S_IDLE);
    assign resultWord = {17'h0_0000, refused, lock, supplyLow, writeErr, eraseErr, seqErr, state != S_IDLE,
        rdData};

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_waitCnt = waitCnt;
        next_rdData = rdData;
        next_seqErr = seqErr;
        next_eraseErr = eraseErr;
        next_writeErr = writeErr;
        next_supplyLow = supplyLow;
        next_lock = lock;
        next_refused = refused;
        next_addrReg = addrReg;
        next_wdataReg = wdataReg;
        next_powerdownResetN = powerdownResetN;
        next_prdata = prdata;
        next_flashPins = flashPins;

        // read data is prepared in the setup cycle so it leaves a flip-flop
        if (apbReq.psel && !apbReq.penable) begin
            unique case (apbReq.paddr)
                OFS_CTRL: next_prdata = {29'h0000_0000, op};
                OFS_ADDR: next_prdata = {12'h000, addrReg};
                OFS_WDATA: next_prdata = {24'h00_0000, wdataReg};
                OFS_RESULT: next_prdata = resultWord;
                OFS_PIN: next_prdata = {31'h0000_0000, powerdownResetN};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (apbWrite && (apbReq.paddr == OFS_ADDR)) begin
            next_addrReg = apbReq.pwdata[FLASH_AW-1:0];
        end
        if (apbWrite && (apbReq.paddr == OFS_WDATA)) begin
            next_wdataReg = apbReq.pwdata[7:0];
        end
        if (apbWrite && (apbReq.paddr == OFS_PIN)) begin
            next_powerdownResetN = apbReq.pwdata[0];
        end

        unique case (state)
            S_IDLE: begin
                if (start) begin
                    next_op = fci_op_type'(apbReq.pwdata[2:0]);
                    next_step = 1'b0;
                    next_refused = 1'b0;
                    if (isAlter(fci_op_type'(apbReq.pwdata[2:0])) && lock) begin
                        next_refused = 1'b1;
                    end else begin
                        next_state = S_WR_LOW;
                        next_flashPins.dataOut = cmdByte(fci_op_type'(apbReq.pwdata[2:0]), 1'b0, wdataReg);
                    end
                end
            end
            S_WR_LOW: begin
                next_state = S_WR_HIGH;
            end
            S_WR_HIGH: begin
                if (!step && isAlter(op)) begin
                    // second write to the same address carries confirm or data
                    next_step = 1'b1;
                    next_state = S_WR_LOW;
                    next_flashPins.dataOut = cmdByte(op, 1'b1, wdataReg);
                end else if (needsPoll(op)) begin
                    // the device needs time to drop ready before a poll means anything
                    next_state = S_SETTLE;
                    next_waitCnt = SETTLE_CYC - 4'h1;
                end else if (readsBack(op)) begin
                    next_state = S_RD_LOW;
                    next_waitCnt = ACCESS_CYC - 4'h1;
                end else begin
                    next_state = S_IDLE;
                    if (op == OP_CLEAR_STATUS) begin
                        next_lock = 1'b0;
                        next_seqErr = 1'b0;
                        next_eraseErr = 1'b0;
                        next_writeErr = 1'b0;
                        next_supplyLow = 1'b0;
                    end
                end
            end
            S_SETTLE: begin
                if (waitCnt == 4'h0) begin
                    next_state = S_RD_LOW;
                    next_waitCnt = ACCESS_CYC - 4'h1;
                end else begin
                    next_waitCnt = waitCnt - 4'h1;
                end
            end
            S_RD_LOW: begin
                if (waitCnt == 4'h0) begin
                    next_state = S_RD_HIGH;
                    if ((op == OP_READ_ARRAY) || (op == OP_READ_ID)) begin
                        next_rdData = flashDataIn;
                    end else begin
                        next_rdData = flashDataIn & STS_USED_MASK;
                    end
                end else begin
                    next_waitCnt = waitCnt - 4'h1;
                end
            end
            S_RD_HIGH: begin
                // strobes are high here, so each poll re-latches the status
                if (needsPoll(op) && (!rdData[STS_READY] || ((op == OP_SUSPEND) && !rdData[STS_SUSPENDED]))) begin
                    next_state = S_RD_LOW;
                    next_waitCnt = ACCESS_CYC - 4'h1;
                end else begin
                    next_state = S_IDLE;
                    if (isAlter(op)) begin
                        // only reached with ready seen, so the error bits are valid
                        next_eraseErr = rdData[STS_ERASE_ERR];
                        next_writeErr = rdData[STS_WRITE_ERR];
                        next_supplyLow = rdData[STS_SUPPLY_LOW];
                        next_lock = lock || rdData[STS_SUPPLY_LOW];
                        next_seqErr = (op == OP_ERASE) && rdData[STS_ERASE_ERR] && rdData[STS_WRITE_ERR];
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase

        next_flashPins.addr = addrReg;
        next_flashPins.ceN = !((next_state == S_WR_LOW) || (next_state == S_WR_HIGH) || (next_state == S_RD_LOW));
        next_flashPins.weN = (next_state != S_WR_LOW);
        next_flashPins.oeN = (next_state != S_RD_LOW);
        next_flashPins.dataOe = (next_state == S_WR_LOW) || (next_state == S_WR_HIGH);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= S_IDLE;
            op <= OP_READ_ARRAY;
            step <= 1'b0;
            waitCnt <= 4'h0;
            rdData <= 8'h00;
            seqErr <= 1'b0;
            eraseErr <= 1'b0;
            writeErr <= 1'b0;
            supplyLow <= 1'b0;
            lock <= 1'b0;
            refused <= 1'b0;
            addrReg <= '0;
            wdataReg <= 8'h00;
            powerdownResetN <= RST_POWERDOWN_RESET_N;
            prdata <= 32'h0000_0000;
            flashPins <= PINS_IDLE;
        end else begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            waitCnt <= next_waitCnt;
            rdData <= next_rdData;
            seqErr <= next_seqErr;
            eraseErr <= next_eraseErr;
            writeErr <= next_writeErr;
            supplyLow <= next_supplyLow;
            lock <= next_lock;
            refused <= next_refused;
            addrReg <= next_addrReg;
            wdataReg <= next_wdataReg;
            powerdownResetN <= next_powerdownResetN;
            prdata <= next_prdata;
            flashPins <= next_flashPins;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence writeOf(logic [7:0] b);
        $fell(flashPins.weN) && flashPins.dataOe && (flashPins.dataOut == b);
    endsequence

    sequence eraseStart;
        writeOf(CMD_ERASE_SETUP) ##0 (op == OP_ERASE);
    endsequence

    status_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state == S_RD_HIGH) && (op != OP_READ_ARRAY) && (op != OP_READ_ID) |-> rdData[2:0] == 3'h0)
        else $error("reserved status bits not masked");

    error_after_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(eraseErr) || $rose(writeErr) |-> $past(state == S_RD_HIGH) && $past(rdData[STS_READY]))
        else $error("error bit taken before ready was seen");

    seq_error_both_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(seqErr) |-> eraseErr && writeErr && (op == OP_ERASE))
        else $error("sequence error without both error bits");

    read_strobe_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(flashPins.oeN) |-> !flashPins.oeN[*2] ##1 (flashPins.oeN && flashPins.ceN))
        else $error("read strobes not returned high after status read");

    supply_lock_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
        start && lock && isAlter(fci_op_type'(apbReq.pwdata[2:0])) |=> refused && (state == S_IDLE)
            && flashPins.weN)
        else $error("altering operation issued while supply-low pending");

    erase_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
        eraseStart |-> ##2 (writeOf(CMD_CONFIRM) and $stable(flashPins.addr)))
        else $error("erase setup not followed by confirm at same address");

    program_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
        writeOf(CMD_WRITE_SETUP) ##0 (op == OP_WRITE) |-> ##2 (writeOf(wdataReg) and $stable(flashPins.addr)))
        else $error("program setup not followed by data write");

    write_data_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !flashPins.weN |=> flashPins.weN && flashPins.dataOe && !flashPins.ceN && $stable(flashPins.dataOut))
        else $error("write data not held across rising write strobe");

endmodule

/* tb/fci_flash_model.sv */
// behavioural byte-wide flash device that answers the host controller
`timescale 1ns/1ps
module fci_flash_model
    import fci_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h5a // arbitrary value
)
(
    input wire fci_pkg::fci_pins_type flashPins,
    input wire logic powerdownResetN,
    input wire logic supplyOk,
    input wire logic failNext,
    input wire logic badConfirm,
    input wire logic noisyReserved,
    input wire logic [7:0] busyTicks,
    output logic [7:0] flashDataIn,
    output logic readyBusyOut
);
    typedef enum logic [1:0] {M_ARRAY, M_ID, M_STATUS} fci_mode_type;
    fci_mode_type mode = M_ARRAY;
    logic [7:0] mem [256];
    logic [7:0] seqStatus = 8'h80;
    logic [7:0] statusLatch = 8'h80;
    logic [7:0] lastOut = 8'h00;
    logic [7:0] pendErr = 8'h00;
    logic [7:0] cmd;
    logic [1:0] pend = 2'd0;
    logic erasing = 1'b0;
    logic susp = 1'b0;
    int busyLeft = 0;
    logic sel;

    assign sel = ~(flashPins.ceN | flashPins.oeN) & powerdownResetN;
    // a released bus shows the inverse of the last byte, so a late sample cannot pass by luck
    assign flashDataIn = !sel ? ~lastOut : mode == M_STATUS ? statusLatch :
        mode == M_ARRAY ? mem[flashPins.addr[7:0]] :
        flashPins.addr == 20'h0_0000 ? MFR_CODE : flashPins.addr == 20'h0_0001 ? DEV_CODE : 8'h00;
    assign readyBusyOut = (busyLeft == 0) || susp;

    initial foreach (mem[i]) mem[i] = 8'hff;
    // reserved bits are made noisy on request to prove the host masks them
    always @(posedge sel) statusLatch = seqStatus | (noisyReserved ? 8'h05 : 8'h00);
    always @(flashDataIn) if (sel) lastOut = flashDataIn;

    task automatic start(input logic erase);
        if (!supplyOk) begin
            seqStatus[3] = 1'b1;
        end else begin
            busyLeft = busyTicks;
            erasing = erase;
            seqStatus[7] = 1'b0;
            pendErr = !failNext ? 8'h00 : erase ? 8'h20 : 8'h10;
            if (!failNext && erase) foreach (mem[i]) mem[i] = 8'hff;
            else if (!failNext) mem[flashPins.addr[7:0]] = mem[flashPins.addr[7:0]] & cmd;
        end
    endtask

    always @(posedge flashPins.weN) begin
        if (!flashPins.ceN && powerdownResetN) begin
            cmd = flashPins.dataOut;
            if (pend != 2'd0) begin
                mode = M_STATUS;
                if (pend == 2'd2 || (cmd == CMD_CONFIRM && !badConfirm)) start(pend == 2'd1);
                else seqStatus[5:4] = 2'b11;
                pend = 2'd0;
            end else if (susp) begin
                // while suspended only array read, status read and resume are taken
                if (cmd == CMD_READ_ARRAY) mode = M_ARRAY;
                else if (cmd == CMD_READ_STATUS) mode = M_STATUS;
                else if (cmd == CMD_CONFIRM) begin
                    susp = 1'b0;
                    seqStatus[7:6] = 2'b00;
                    mode = M_STATUS;
                end
            end else if (busyLeft > 0) begin
                if (cmd == CMD_READ_STATUS) mode = M_STATUS;
                else if (cmd == CMD_SUSPEND && erasing) begin
                    // the coarse sequencer treats every step boundary as its pause point
                    susp = 1'b1;
                    seqStatus[7:6] = 2'b11;
                    mode = M_STATUS;
                end
            end else begin
                case (cmd)
                    CMD_READ_ARRAY: mode = M_ARRAY;
                    CMD_READ_ID: mode = M_ID;
                    CMD_READ_STATUS: mode = M_STATUS;
                    CMD_CLEAR_STATUS: seqStatus[5:3] = 3'b000;
                    CMD_ERASE_SETUP: pend = 2'd1;
                    CMD_WRITE_SETUP, 8'h10: pend = 2'd2;
                    default: ;
                endcase
            end
        end
    end

    // coarse sequencer steps; busyTicks sets prompt or slow completion
    always #100 begin
        if (busyLeft > 0 && !susp) begin
            busyLeft = busyLeft - 1;
            if (busyLeft == 0) seqStatus = seqStatus | pendErr | 8'h80;
        end
    end
    always @(negedge powerdownResetN) begin
        busyLeft = 0;
        pend = 2'd0;
        susp = 1'b0;
        erasing = 1'b0;
    end
    always @(posedge powerdownResetN) begin
        mode = M_ARRAY;
        seqStatus = 8'h80;
    end
endmodule

/* tb/flash_command_interface_tb.sv */
// self-checking bench for the flash command host controller
`timescale 1ns/1ps
module flash_command_interface_tb;
    import fci_pkg::*;
    localparam logic [7:0] MFR = 8'h3c;
    localparam logic [7:0] DEV = 8'h5a;
    localparam logic [31:0] ALL = 32'h0000_7fff;
    localparam logic [31:0] LOW = 32'h0000_00ff;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    fci_apb_req_type apbReq = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fci_pins_type flashPins;
    logic [7:0] flashDataIn;
    logic readyBusyOut;
    logic powerdownResetN;
    logic supplyOk = 1'b1;
    logic failNext = 1'b0;
    logic badConfirm = 1'b0;
    logic noisyReserved = 1'b1;
    logic [7:0] busyTicks = 8'd2;
    logic [7:0] seed = 8'd82;
    logic [7:0] wbyte;
    logic [19:0] waddr;
    logic [31:0] rdata;
    logic [76:0] note;
    logic [76:0] notes [$];
    int miscompares = 0;
    int numChecks = 0;
    int cycles = 0;

    fci_host_ctrl fci_host_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flashPins(flashPins), .flashDataIn(flashDataIn),
        .readyBusyOut(readyBusyOut), .powerdownResetN(powerdownResetN));
    fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fci_flash_model_inst (.flashPins(flashPins),
        .powerdownResetN(powerdownResetN), .supplyOk(supplyOk), .failNext(failNext), .badConfirm(badConfirm),
        .noisyReserved(noisyReserved), .busyTicks(busyTicks), .flashDataIn(flashDataIn),
        .readyBusyOut(readyBusyOut));

    always #25 clk_sys = ~clk_sys;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // bus driver: notes the expectation, then runs one APB transfer
    // -----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input logic [31:0] mask,
        input logic [31:0] exp, input logic err = 1'b0);
        notes.push_back({err, addr, mask, exp});
        @(posedge clk_sys);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= addr;
        apbReq.pwdata <= wdata;
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdata = prdata;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic waitOp(input logic [31:0] mask, input logic [31:0] exp);
        rdata = 32'h0000_0100;
        for (int i = 0; i < 300 && rdata[RES_BUSY] !== 1'b0; i++) apb(1'b0, OFS_RESULT, '0, '0, '0);
        check("busy", {32'h0000_0000, rdata[RES_BUSY]}, 33'h0_0000_0000);
        apb(1'b0, OFS_RESULT, '0, mask, exp);
    endtask

    task automatic runOp(input logic [2:0] op, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b1, OFS_CTRL, 32'(op), '0, '0);
        waitOp(mask, exp);
    endtask

    // -----------------------------------------------------------------
    // monitor and timeout
    // -----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end else if (apbReq.psel && apbReq.penable && pready === 1'b1) begin
            note = notes.pop_front();
            check($sformatf("apb %h", note[75:64]), {pslverr, prdata & note[63:32]}, {note[76], note[31:0]});
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, OFS_RESULT, '0, 32'hffff_ffff, '0);
        apb(1'b0, OFS_PIN, '0, 32'h0000_0001, 32'h0000_0001);
        apb(1'b0, 12'h014, '0, 32'hffff_ffff, '0, 1'b1);
        seed = lfsr(seed);
        waddr = {seed[3:0], 8'h00, seed};
        seed = lfsr(seed);
        wbyte = seed;
        apb(1'b1, OFS_ADDR, {12'h000, waddr}, '0, '0);
        apb(1'b0, OFS_ADDR, '0, 32'h000f_ffff, {12'h000, waddr});
        apb(1'b1, OFS_WDATA, {24'h00_0000, wbyte}, '0, '0);
        busyTicks <= 8'd20;
        apb(1'b1, OFS_CTRL, 32'h0000_0004, '0, '0);
        apb(1'b1, OFS_CTRL, 32'h0000_0002, '0, '0);
        apb(1'b0, OFS_CTRL, '0, 32'h0000_0007, 32'h0000_0004);
        waitOp(ALL, 32'h0000_0080);
        busyTicks <= 8'd2;
        runOp(3'd5, ALL, 32'h0000_0080);
        runOp(3'd0, ALL, {24'h00_0000, wbyte});
        apb(1'b1, OFS_ADDR, '0, '0, '0);
        runOp(3'd1, ALL, {24'h00_0000, MFR});
        apb(1'b1, OFS_ADDR, 32'h0000_0001, '0, '0);
        runOp(3'd1, ALL, {24'h00_0000, DEV});
        failNext <= 1'b1;
        runOp(3'd5, ALL, 32'h0000_0890);
        failNext <= 1'b0;
        runOp(3'd5, ALL, 32'h0000_0890);
        runOp(3'd2, LOW, 32'h0000_0090);
        apb(1'b1, OFS_PIN, '0, '0, '0);
        apb(1'b1, OFS_PIN, 32'h0000_0001, '0, '0);
        runOp(3'd2, LOW, 32'h0000_0080);
        badConfirm <= 1'b1;
        runOp(3'd4, ALL, 32'h0000_0eb0);
        badConfirm <= 1'b0;
        runOp(3'd3, 32'h0000_7e00, '0);
        runOp(3'd2, LOW, 32'h0000_0080);
        supplyOk <= 1'b0;
        runOp(3'd5, ALL, 32'h0000_3088);
        runOp(3'd5, 32'h0000_4000, 32'h0000_4000);
        runOp(3'd3, 32'h0000_3000, '0);
        supplyOk <= 1'b1;
        noisyReserved <= 1'b0;
        runOp(3'd4, ALL, 32'h0000_0080);
        runOp(3'd7, ALL, 32'h0000_0080);
        runOp(3'd2, LOW, 32'h0000_0080);
        conclude();
    end
endmodule
